// File: core/lgm_defines.svh
`ifndef LGM_DEFINES_SVH
`define LGM_DEFINES_SVH

// Register offsets
`define LGM_OFF_FIRST_GAIN  8'h09
`define LGM_OFF_THIRD_GAIN  8'h0b
`define LGM_OFF_MAP_CH0_3   8'h0c
`define LGM_OFF_MAP_CH4_7   8'h0d
`define LGM_OFF_MAP_CH8_11  8'h0e
`define LGM_OFF_MAP_CH12_15 8'h0f
`define LGM_OFF_MAP_CH16_17 8'h10
// Register of a neighbouring slice, decoded nowhere here
`define LGM_OFF_OUTSIDE     8'h0a

// Field positions
`define LGM_GAIN_MSB        6
`define LGM_GAIN_W          7
`define LGM_FIELD_W         2
`define LGM_MAP4_USED_W     4
`define LGM_CHANNELS        18

// Reset values
`define LGM_GAIN_RESET      7'h40
`define LGM_MAP_RESET       8'h00
`define LGM_MAP4_RESET      4'h0
`define LGM_READ_IDLE       8'h00

`endif

// File: core/lgm_group_decode.sv
`timescale 1ns/100ps
`include "lgm_defines.svh"

module lgm_group_decode
	import lgm_pkg::*;
(
	input  wire logic [35:0] groupMap,   // Packed channel fields, ch0 lowest
	output logic      [17:0] grpOneSel,  // Channels bound to group one
	output logic      [17:0] grpTwoSel,  // Channels bound to group two
	output logic      [17:0] grpThreeSel // Channels bound to group three
);

	always_comb begin
		lgm_group_t choice;
		choice = LGM_GRP_NONE;
		grpOneSel = 18'h00000;
		grpTwoSel = 18'h00000;
		grpThreeSel = 18'h00000;
		for (int ch = 0; ch < `LGM_CHANNELS; ch++) begin
			choice = lgm_group_t'(groupMap[ch*`LGM_FIELD_W +: `LGM_FIELD_W]);
			case (choice)
				LGM_GRP_ONE:   grpOneSel[ch] = 1'b1;
				LGM_GRP_TWO:   grpTwoSel[ch] = 1'b1;
				LGM_GRP_THREE: grpThreeSel[ch] = 1'b1;
				default: ;
			endcase
		end
	end

endmodule : lgm_group_decode

// File: core/lgm_pkg.sv
package lgm_pkg;

	// Group choice held in each 2-bit channel field
	typedef enum logic [1:0] {
		LGM_GRP_NONE = 2'h0,
		LGM_GRP_ONE  = 2'h1,
		LGM_GRP_TWO  = 2'h2,
		LGM_GRP_THREE = 2'h3
	} lgm_group_t;

	// Whole state of the register slice
	typedef struct packed {
		logic [6:0]   firstGain;
		logic [6:0]   thirdGain;
		logic [7:0]   mapCh0To3;
		logic [7:0]   mapCh4To7;
		logic [7:0]   mapCh8To11;
		logic [7:0]   mapCh12To15;
		logic [3:0]   mapCh16To17;
		logic [7:0]   rdData;
		logic [17:0]  grpOne;
		logic [17:0]  grpTwo;
		logic [17:0]  grpThree;
		logic [125:0] sinkGain;
	} lgm_state_t;

endpackage : lgm_pkg

// File: core/lgm_regs.sv
// What this block does
// - Seven-bit third colour gain, reset 40h, drives sinks 2,5,8,11,14,17.
// - Third colour gain register decoded at offset Bh, resets to 40h.
// - Field 0 means no group; 1,2,3 select group one, two, three.
// - Offset Ch holds channels 0 to 3, channel 0 in bits 1-0.
// - Offset Dh holds channels 4 to 7, lowest channel lowest.
// - Offset Eh holds channels 8 to 11, lowest channel lowest.
// - Offset Fh is decoded as a fourth map register.
// - Offset 10h is decoded as the fifth map register.
// - All map registers clear on reset, no channel in any group.
// - Fourth map register holds channels 12 to 15, channel 15 at top.
// - Fifth map: channel 16 bits 1-0, 17 bits 3-2, top reads zero.
// - First colour gain, seven bits, drives sinks 0,3,6,9,12,15.
`timescale 1ns/100ps
`include "lgm_defines.svh"

module lgm_regs
	import lgm_pkg::*;
(
	input  wire logic         core_clk,         // System clock, 10 MHz
	input  wire logic         reset,            // Synchronous, active high
	input  wire logic [7:0]   regAddr,          // Register offset
	input  wire logic [7:0]   regWrData,        // Write data
	input  wire logic         regWrEn,          // Write strobe
	input  wire logic         regRdEn,          // Read strobe
	input  wire logic [6:0]   secondColourGain, // Gain for sinks 1,4,..,16
	output logic      [7:0]   regRdData,        // Read data, cycle after
	output logic      [6:0]   firstColourGain,  // First colour gain
	output logic      [6:0]   thirdColourGain,  // Third colour gain
	output logic      [35:0]  groupMap,         // All channel fields
	output logic      [17:0]  groupOneSinks,    // Sinks on group one PWM
	output logic      [17:0]  groupTwoSinks,    // Sinks on group two PWM
	output logic      [17:0]  groupThreeSinks,  // Sinks on group three PWM
	output logic      [125:0] sinkColourGain    // Per-sink gain, 7 bits each
);

	// ------------------------------------------------------------------
	// State and constants
	// ------------------------------------------------------------------
	localparam lgm_state_t RESET_STATE = '{
		firstGain: `LGM_GAIN_RESET,
		thirdGain: `LGM_GAIN_RESET,
		mapCh0To3: `LGM_MAP_RESET,
		mapCh4To7: `LGM_MAP_RESET,
		mapCh8To11: `LGM_MAP_RESET,
		mapCh12To15: `LGM_MAP_RESET,
		mapCh16To17: `LGM_MAP4_RESET,
		rdData: `LGM_READ_IDLE,
		default: '0
	};

	lgm_state_t  st_q;
	lgm_state_t  st_d;
	logic [35:0] mapNow;
	logic [17:0] decOne;
	logic [17:0] decTwo;
	logic [17:0] decThree;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [35:0] packMap(input lgm_state_t s);
		packMap = {s.mapCh16To17, s.mapCh12To15, s.mapCh8To11,
			s.mapCh4To7, s.mapCh0To3};
	endfunction : packMap

	function automatic logic [7:0] readValue(input logic [7:0] addr,
		input lgm_state_t s);
		case (addr)
			`LGM_OFF_FIRST_GAIN:  readValue = {1'b0, s.firstGain};
			`LGM_OFF_THIRD_GAIN:  readValue = {1'b0, s.thirdGain};
			`LGM_OFF_MAP_CH0_3:   readValue = s.mapCh0To3;
			`LGM_OFF_MAP_CH4_7:   readValue = s.mapCh4To7;
			`LGM_OFF_MAP_CH8_11:  readValue = s.mapCh8To11;
			`LGM_OFF_MAP_CH12_15: readValue = s.mapCh12To15;
			`LGM_OFF_MAP_CH16_17: readValue = {4'h0, s.mapCh16To17};
			default:              readValue = `LGM_READ_IDLE;
		endcase
	endfunction : readValue

	assign mapNow = packMap(st_q);

	// ------------------------------------------------------------------
	// Channel to group decode
	// ------------------------------------------------------------------
	// field decode
	lgm_group_decode u_decode (
		.groupMap    (mapNow),
		.grpOneSel   (decOne),
		.grpTwoSel   (decTwo),
		.grpThreeSel (decThree)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rdData = `LGM_READ_IDLE;
		if (regWrEn) begin
			case (regAddr)
				`LGM_OFF_FIRST_GAIN:
					st_d.firstGain = regWrData[`LGM_GAIN_MSB:0];
				`LGM_OFF_THIRD_GAIN:
					st_d.thirdGain = regWrData[`LGM_GAIN_MSB:0];
				`LGM_OFF_MAP_CH0_3:   st_d.mapCh0To3 = regWrData;
				`LGM_OFF_MAP_CH4_7:   st_d.mapCh4To7 = regWrData;
				`LGM_OFF_MAP_CH8_11:  st_d.mapCh8To11 = regWrData;
				`LGM_OFF_MAP_CH12_15: st_d.mapCh12To15 = regWrData;
				`LGM_OFF_MAP_CH16_17:
					st_d.mapCh16To17 = regWrData[`LGM_MAP4_USED_W-1:0];
				// Other offsets, reserved, left alone
				default: ;
			endcase
		end
		if (regRdEn) begin
			st_d.rdData = readValue(regAddr, st_q);
		end
		st_d.grpOne = decOne;
		st_d.grpTwo = decTwo;
		st_d.grpThree = decThree;
		for (int ch = 0; ch < `LGM_CHANNELS; ch++) begin
			case (ch % 3)
				0: st_d.sinkGain[ch*`LGM_GAIN_W +: `LGM_GAIN_W] =
					st_q.firstGain;
				1: st_d.sinkGain[ch*`LGM_GAIN_W +: `LGM_GAIN_W] =
					secondColourGain;
				default: st_d.sinkGain[ch*`LGM_GAIN_W +: `LGM_GAIN_W] =
					st_q.thirdGain;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= RESET_STATE;
		end else begin
			st_q <= st_d;
		end
	end

	assign regRdData = st_q.rdData;
	assign firstColourGain = st_q.firstGain;
	assign thirdColourGain = st_q.thirdGain;
	assign groupMap = mapNow;
	assign groupOneSinks = st_q.grpOne;
	assign groupTwoSinks = st_q.grpTwo;
	assign groupThreeSinks = st_q.grpThree;
	assign sinkColourGain = st_q.sinkGain;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence seqWrite(logic [7:0] off);
		regWrEn && (regAddr == off);
	endsequence

	sequence seqRead(logic [7:0] off);
		regRdEn && (regAddr == off);
	endsequence

	sequence seqResetRelease;
		$fell(reset);
	endsequence

	AST_THIRD_GAIN_WRITE: assert property (
		seqWrite(`LGM_OFF_THIRD_GAIN) |=>
			thirdColourGain == $past(regWrData[6:0])
	) else $error("third gain did not take written value");

	AST_THIRD_GAIN_SINKS: assert property (
		seqWrite(`LGM_OFF_THIRD_GAIN) ##1 !regWrEn |=>
			sinkColourGain[20:14] == thirdColourGain &&
			sinkColourGain[125:119] == thirdColourGain &&
			sinkColourGain[41:35] == thirdColourGain
	) else $error("third gain not steered to its sinks");

	AST_THIRD_GAIN_RESET: assert property (
		seqResetRelease |-> thirdColourGain == 7'h40 &&
			firstColourGain == 7'h40
	) else $error("gain reset value wrong");

	AST_GROUP_DECODE: assert property (
		$past(groupMap[1:0]) == 2'h1 |->
			groupOneSinks[0] && !groupTwoSinks[0] && !groupThreeSinks[0]
	) else $error("channel 0 group one decode wrong");

	AST_GROUP_NONE: assert property (
		$past(groupMap[35:34]) == 2'h0 && !$past(reset) |->
			!groupOneSinks[17] && !groupTwoSinks[17] &&
			!groupThreeSinks[17]
	) else $error("channel 17 bound while field is zero");

	AST_MAP0_WRITE: assert property (
		seqWrite(`LGM_OFF_MAP_CH0_3) |=>
			groupMap[7:6] == $past(regWrData[7:6]) &&
			groupMap[1:0] == $past(regWrData[1:0])
	) else $error("map register 0 field placement wrong");

	AST_MAP1_WRITE: assert property (
		seqWrite(`LGM_OFF_MAP_CH4_7) |=>
			groupMap[15:8] == $past(regWrData)
	) else $error("map register 1 not stored");

	AST_MAP2_WRITE: assert property (
		seqWrite(`LGM_OFF_MAP_CH8_11) |=>
			groupMap[23:16] == $past(regWrData)
	) else $error("map register 2 not stored");

	AST_MAP3_WRITE: assert property (
		seqWrite(`LGM_OFF_MAP_CH12_15) |=>
			groupMap[31:30] == $past(regWrData[7:6]) &&
			groupMap[25:24] == $past(regWrData[1:0])
	) else $error("map register 3 field placement wrong");

	AST_MAP4_WRITE: assert property (
		seqWrite(`LGM_OFF_MAP_CH16_17) |=>
			groupMap[35:32] == $past(regWrData[3:0])
	) else $error("map register 4 not stored");

	AST_MAP_RESET: assert property (
		seqResetRelease |-> groupMap == 36'h000000000
	) else $error("map not cleared by reset");

	AST_MAP4_READ_TOP: assert property (
		seqRead(`LGM_OFF_MAP_CH16_17) |=> regRdData[7:4] == 4'h0
	) else $error("reserved map bits read nonzero");

	AST_FIRST_GAIN_SINKS: assert property (
		seqWrite(`LGM_OFF_FIRST_GAIN) ##1 !regWrEn |=>
			sinkColourGain[6:0] == firstColourGain &&
			sinkColourGain[111:105] == firstColourGain
	) else $error("first gain not steered to its sinks");

	AST_GAIN_TOP_ZERO: assert property (
		seqRead(`LGM_OFF_THIRD_GAIN) |=>
			regRdData == {1'b0, $past(thirdColourGain)}
	) else $error("gain readback wrong");

	AST_READBACK: assert property (
		seqRead(`LGM_OFF_MAP_CH0_3) |=>
			regRdData == $past(groupMap[7:0])
	) else $error("map readback wrong");

	AST_READ_NO_EFFECT: assert property (
		regRdEn && !regWrEn |=> $stable(groupMap) &&
			$stable(thirdColourGain) && $stable(firstColourGain)
	) else $error("read changed register contents");

	AST_READ_IDLE: assert property (
		!regRdEn |=> regRdData == 8'h00
	) else $error("read data present without read");

	AST_GROUP_THREE: assert property (
		$past(groupMap[35:34]) == 2'h3 && !$past(reset) |->
			groupThreeSinks[17] && !groupOneSinks[17] &&
			!groupTwoSinks[17]
	) else $error("channel 17 group three decode wrong");

	AST_GROUP_TWO: assert property (
		$past(groupMap[11:10]) == 2'h2 && !$past(reset) |->
			groupTwoSinks[5] && !groupOneSinks[5] && !groupThreeSinks[5]
	) else $error("channel 5 group two decode wrong");

	AST_MAP3_READ: assert property (
		seqRead(`LGM_OFF_MAP_CH12_15) |=>
			regRdData[7:6] == $past(groupMap[31:30]) &&
			regRdData[1:0] == $past(groupMap[25:24])
	) else $error("map register 3 readback placement wrong");

	AST_MAP4_FIELDS: assert property (
		seqWrite(`LGM_OFF_MAP_CH16_17) |=>
			groupMap[33:32] == $past(regWrData[1:0]) &&
			groupMap[35:34] == $past(regWrData[3:2])
	) else $error("map register 4 field placement wrong");

	AST_FIRST_GAIN_WRITE: assert property (
		seqWrite(`LGM_OFF_FIRST_GAIN) |=>
			firstColourGain == $past(regWrData[6:0])
	) else $error("first gain did not take written value");

	// first gain bit 7 reads zero
	AST_FIRST_GAIN_TOP: assert property (
		seqRead(`LGM_OFF_FIRST_GAIN) |=>
			regRdData == {1'b0, $past(firstColourGain)}
	) else $error("first gain readback wrong");

	AST_MAP4_READBACK: assert property (
		seqRead(`LGM_OFF_MAP_CH16_17) |=>
			regRdData == {4'h0, $past(groupMap[35:32])}
	) else $error("map register 4 readback wrong");

	AST_OUTSIDE_READ: assert property (
		seqRead(`LGM_OFF_OUTSIDE) |=> regRdData == 8'h00
	) else $error("read outside the slice returned data");

	AST_OUTSIDE_WRITE: assert property (
		seqWrite(`LGM_OFF_OUTSIDE) |=> $stable(groupMap) &&
			$stable(thirdColourGain) && $stable(firstColourGain)
	) else $error("write outside the slice changed contents");

endmodule : lgm_regs

// File: verification/lgm_bench.sv
`timescale 1ns/100ps

module testbench import lgm_pkg::*;;

	logic         core_clk;
	logic         reset;
	logic [7:0]   regAddr;
	logic [7:0]   regWrData;
	logic         regWrEn;
	logic         regRdEn;
	logic [6:0]   secondColourGain;
	logic [7:0]   regRdData;
	logic [6:0]   firstColourGain;
	logic [6:0]   thirdColourGain;
	logic [35:0]  groupMap;
	logic [17:0]  groupOneSinks;
	logic [17:0]  groupTwoSinks;
	logic [17:0]  groupThreeSinks;
	logic [125:0] sinkColourGain;
	logic [7:0]   mdl [0:31];
	int           n_fail;
	int           checks;
	int           cycles;
	logic [7:0]   addr;

	lgm_regs dut (
		.core_clk         (core_clk),
		.reset            (reset),
		.regAddr          (regAddr),
		.regWrData        (regWrData),
		.regWrEn          (regWrEn),
		.regRdEn          (regRdEn),
		.secondColourGain (secondColourGain),
		.regRdData        (regRdData),
		.firstColourGain  (firstColourGain),
		.thirdColourGain  (thirdColourGain),
		.groupMap         (groupMap),
		.groupOneSinks    (groupOneSinks),
		.groupTwoSinks    (groupTwoSinks),
		.groupThreeSinks  (groupThreeSinks),
		.sinkColourGain   (sinkColourGain)
	);

	always #50 core_clk = ~core_clk;

	// ----------------------------------------
	// Expectation helpers
	// ----------------------------------------
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h09, 8'h0b: wmask = 8'h7f;
			8'h0c, 8'h0d, 8'h0e, 8'h0f: wmask = 8'hff;
			8'h10: wmask = 8'h0f;
			default: wmask = 8'h00;
		endcase
	endfunction : wmask

	function automatic logic [35:0] expMap();
		expMap = {mdl[16][3:0], mdl[15], mdl[14], mdl[13], mdl[12]};
	endfunction : expMap

	function automatic logic [17:0] expMask(input logic [1:0] g);
		logic [35:0] m;
		m = expMap();
		for (int c = 0; c < 18; c++) begin
			expMask[c] = (m[2*c +: 2] == g);
		end
	endfunction : expMask

	function automatic logic [125:0] expGain();
		for (int c = 0; c < 18; c++) begin
			case (c % 3)
				0: expGain[7*c +: 7] = mdl[9][6:0];
				1: expGain[7*c +: 7] = secondColourGain;
				default: expGain[7*c +: 7] = mdl[11][6:0];
			endcase
		end
	endfunction : expGain

	function automatic void mdlReset();
		for (int i = 0; i < 32; i++) begin
			mdl[i] = 8'h00;
		end
		mdl[9] = 8'h40;
		mdl[11] = 8'h40;
	endfunction : mdlReset

	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		secondColourGain <= 7'($urandom);
		@(posedge core_clk);
		regWrEn <= 1'b0;
		mdl[a[4:0]] = (d & wmask(a)) | (mdl[a[4:0]] & ~wmask(a));
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic [7:0] want;
		want = (a >= 8'h09 && a <= 8'h10) ? mdl[a[4:0]] : 8'h00;
		@(posedge core_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdData, want);
	endtask : rd

	task automatic checkOuts();
		repeat (3) @(posedge core_clk);
		#1;
		chk(firstColourGain, mdl[9][6:0]);
		chk(thirdColourGain, mdl[11][6:0]);
		chk(groupMap, expMap());
		chk(groupOneSinks, expMask(2'h1));
		chk(groupTwoSinks, expMask(2'h2));
		chk(groupThreeSinks, expMask(2'h3));
		chk(sinkColourGain, expGain());
	endtask : checkOuts

	task automatic conclude();
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		secondColourGain = 7'h00;
		n_fail = 0;
		checks = 0;
		cycles = 0;
		mdlReset();
		void'($urandom(22662));
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		checkOuts();
		// Reset values; offsets around the slice read as zero
		for (int a = 8; a <= 17; a++) begin
			rd(8'(a));
		end
		@(posedge core_clk);
		#1;
		chk(regRdData, 8'h00);
		// Reserved gain bit and unused map bits
		wr(8'h0b, 8'hff);
		rd(8'h0b);
		wr(8'h09, 8'hff);
		rd(8'h09);
		wr(8'h10, 8'hff);
		rd(8'h10);
		checkOuts();
		wr(8'h0c, 8'he4);
		checkOuts();
		// Every group code in every channel field
		for (int g = 0; g < 4; g++) begin
			for (int a = 12; a <= 16; a++) begin
				wr(8'(a), {4{2'(g)}});
			end
			checkOuts();
		end
		// Random traffic; 0Ah belongs to another slice and is ignored
		for (int i = 0; i < 80; i++) begin
			addr = 8'h09 + 8'($urandom_range(7));
			wr(addr, 8'($urandom));
			checkOuts();
			rd(addr);
		end
		// Reset in mid-run
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		mdlReset();
		checkOuts();
		rd(8'h0f);
		conclude();
	end

endmodule : testbench
